// File: core/isa_fwd_consts.svh
// Constants for the ISA-to-PCI memory forward decoder: register indices, fields, reset values.
//------------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------------
`ifndef ISA_FWD_CONSTS_SVH
`define ISA_FWD_CONSTS_SVH

// Register indices; the Wishbone byte address is four times the index.
`define FWD_IDX_CONTROL 8'h48
`define FWD_IDX_ROM 8'h49
`define FWD_IDX_HOLE_BOTTOM 8'h4A
`define FWD_IDX_HOLE_TOP 8'h4B
`define FWD_IDX_UTILITY_CS 8'h50
`define FWD_IDX_STATUS 8'h51
`define FWD_IDX_FWD_COUNT 8'h52
`define FWD_IDX_KEEP_COUNT 8'h53

// Reset values.
`define FWD_RST_CONTROL 8'h01
`define FWD_RST_ROM 8'h00
`define FWD_RST_HOLE_BOTTOM 8'h10
`define FWD_RST_HOLE_TOP 8'h0F
`define FWD_RST_UTILITY_CS 8'h00

// Field positions.
`define FWD_CTRL_TOP_MSB 7
`define FWD_CTRL_TOP_LSB 4
`define FWD_CTRL_LOW_MSB 3
`define FWD_CTRL_LOW_LSB 0
`define FWD_UCS_BIOS_BIT 6
`define FWD_LOW_BIOS_BIT 3

`endif

// File: core/isa_fwd_pkg.sv
// Types shared by the ISA-to-PCI memory forward decoder.
package isa_fwd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DECIDE = 3'b010,
      ST_HOLD = 3'b100
   } cycle_state_t;

   typedef enum logic [2:0] {
      RG_LOW_BASE = 3'h0,
      RG_LOW_EXT = 3'h1,
      RG_VIDEO = 3'h2,
      RG_ROM = 3'h3,
      RG_BIOS = 3'h4,
      RG_HIGH_BIOS = 3'h5,
      RG_EXTENDED = 3'h6
   } region_t;

endpackage

// File: core/forward_decision.sv
// Combinational forward-or-keep decision for one ISA memory address.
`timescale 1ns/1ns
`include "isa_fwd_consts.svh"
module forward_decision
   import isa_fwd_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   // Address under decision.
   input wire logic [ADDR_W-1:0] addr,
   // Configuration.
   input wire logic [3:0] lowEnable,
   input wire logic [7:0] romEnable,
   input wire logic [3:0] regionTop,
   input wire logic [7:0] holeBottom,
   input wire logic [7:0] holeTop,
   input wire logic biosCsEnable,
   // Result.
   output logic forward,
   output region_t region
);

   if (ADDR_W != 24) begin : g_width_check
      $error("forward_decision serves a 24-bit ISA address only");
   end

   logic [7:0] romHit;
   logic inHole;
   logic below1M;
   logic rawForward;

   // One comparator per 16-Kbyte ROM block between 768K and 896K.
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_rom
         assign romHit[b] = (addr[19:14] == 6'(6'h30 + b)) && romEnable[b];
      end
   endgenerate

   assign below1M = (addr[23:20] == 4'h0);
   // An inverted pair of bounds matches nothing, which disables the hole.
   assign inHole = (addr[23:16] >= holeBottom) && (addr[23:16] <= holeTop);

   always_comb begin
      rawForward = 1'b0;
      region = RG_EXTENDED;
      if (below1M) begin
         if (addr[19] == 1'b0) begin
            region = RG_LOW_BASE;
            rawForward = lowEnable[0];
         end else if (addr[19:17] == 3'b100) begin
            region = RG_LOW_EXT;
            rawForward = lowEnable[1];
         end else if (addr[19:17] == 3'b101) begin
            region = RG_VIDEO;
            rawForward = lowEnable[2];
         end else if (addr[19:17] == 3'b110) begin
            region = RG_ROM;
            rawForward = |romHit;
         end else if (addr[19:16] == 4'hE) begin
            region = RG_BIOS;
            rawForward = lowEnable[`FWD_LOW_BIOS_BIT] && !biosCsEnable;
         end else begin
            region = RG_HIGH_BIOS;
            rawForward = 1'b0;
         end
      end else begin
         region = RG_EXTENDED;
         rawForward = (addr[23:20] <= regionTop);
      end
   end

   assign forward = rawForward && !inHole;

endmodule

// File: core/isa_to_pci_memory_forward_decoder.sv
// Top of the ISA-to-PCI memory forward decoder with its Wishbone register file.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "isa_fwd_consts.svh"
module isa_to_pci_memory_forward_decoder
   import isa_fwd_pkg::*;
#(
   parameter int ADDR_W = 24,
   parameter int WB_ADR_W = 12,
   parameter int COUNT_W = 8
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // ISA master or DMA memory cycle.
   input wire logic memCycleStart,
   input wire logic memCycleEnd,
   input wire logic [ADDR_W-1:0] memAddr,
   // Decision.
   output logic decisionValid,
   output logic forwardToPci,
   output logic keepOnIsa,
   output logic cycleBusy
);

   //---------------------------------------------------------------------------
   // Parameter checks
   //---------------------------------------------------------------------------

   if (ADDR_W != 24) begin : g_addr_check
      $error("ADDR_W must be 24");
   end
   if (WB_ADR_W < 11) begin : g_adr_check
      $error("WB_ADR_W must exceed the register index field");
   end
   if (COUNT_W < 1 || COUNT_W > 8) begin : g_count_check
      $error("COUNT_W must be 1 to 8");
   end

   //---------------------------------------------------------------------------
   // Register index decode
   //---------------------------------------------------------------------------

   typedef enum logic [3:0] {
      SEL_NONE = 4'h0,
      SEL_CONTROL = 4'h1,
      SEL_ROM = 4'h2,
      SEL_HOLE_BOTTOM = 4'h3,
      SEL_HOLE_TOP = 4'h4,
      SEL_UTILITY_CS = 4'h5,
      SEL_STATUS = 4'h6,
      SEL_FWD_COUNT = 4'h7,
      SEL_KEEP_COUNT = 4'h8
   } reg_sel_t;

   // Maps a Wishbone byte address onto a register; upper bits must be zero.
   function automatic reg_sel_t decodeIndex(input logic [WB_ADR_W-1:0] adr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (adr[1:0] == 2'b00 && adr[WB_ADR_W-1:10] == '0) begin
         case (adr[9:2])
            `FWD_IDX_CONTROL: sel = SEL_CONTROL;
            `FWD_IDX_ROM: sel = SEL_ROM;
            `FWD_IDX_HOLE_BOTTOM: sel = SEL_HOLE_BOTTOM;
            `FWD_IDX_HOLE_TOP: sel = SEL_HOLE_TOP;
            `FWD_IDX_UTILITY_CS: sel = SEL_UTILITY_CS;
            `FWD_IDX_STATUS: sel = SEL_STATUS;
            `FWD_IDX_FWD_COUNT: sel = SEL_FWD_COUNT;
            `FWD_IDX_KEEP_COUNT: sel = SEL_KEEP_COUNT;
            default: sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   //---------------------------------------------------------------------------
   // Wishbone handshake
   //---------------------------------------------------------------------------

   logic busRequest;
   logic writeStrobe;
   reg_sel_t accessSel;

   assign busRequest = wb_cyc_i && wb_stb_i;
   assign accessSel = decodeIndex(wb_adr_i);
   // Writes land on the edge where the master sees the acknowledge.
   assign writeStrobe = busRequest && wb_we_i && wb_ack_o && wb_sel_i[0];

   // Acknowledge one cycle after the request and drop it the cycle after.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= busRequest && !wb_ack_o;
      end
   end

   //---------------------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------------------

   logic [7:0] forwardRegionControl;
   logic [7:0] romBlockForwardEnable;
   logic [7:0] forwardHoleBottom;
   logic [7:0] forwardHoleTop;
   logic [7:0] utilityBusChipSelectA;

   // Control: low block enables in the low nibble, region top in the high one.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         forwardRegionControl <= `FWD_RST_CONTROL;
      end else if (writeStrobe && accessSel == SEL_CONTROL) begin
         forwardRegionControl <= wb_dat_i[7:0];
      end
   end

   // One enable per 16-Kbyte expansion ROM block.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         romBlockForwardEnable <= `FWD_RST_ROM;
      end else if (writeStrobe && accessSel == SEL_ROM) begin
         romBlockForwardEnable <= wb_dat_i[7:0];
      end
   end

   // Hole bounds; the reset pair is inverted, so the hole starts disabled.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         forwardHoleBottom <= `FWD_RST_HOLE_BOTTOM;
      end else if (writeStrobe && accessSel == SEL_HOLE_BOTTOM) begin
         forwardHoleBottom <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         forwardHoleTop <= `FWD_RST_HOLE_TOP;
      end else if (writeStrobe && accessSel == SEL_HOLE_TOP) begin
         forwardHoleTop <= wb_dat_i[7:0];
      end
   end

   // Utility chip-select register; only the BIOS chip-select enable is used here.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         utilityBusChipSelectA <= `FWD_RST_UTILITY_CS;
      end else if (writeStrobe && accessSel == SEL_UTILITY_CS) begin
         utilityBusChipSelectA <= wb_dat_i[7:0];
      end
   end

   //---------------------------------------------------------------------------
   // Decision logic
   //---------------------------------------------------------------------------

   logic [ADDR_W-1:0] cycleAddr;
   logic decideForward;
   region_t decideRegion;

   forward_decision #(
      .ADDR_W(ADDR_W)
   ) u_decision (
      .addr(cycleAddr),
      .lowEnable(forwardRegionControl[`FWD_CTRL_LOW_MSB:`FWD_CTRL_LOW_LSB]),
      .romEnable(romBlockForwardEnable),
      .regionTop(forwardRegionControl[`FWD_CTRL_TOP_MSB:`FWD_CTRL_TOP_LSB]),
      .holeBottom(forwardHoleBottom),
      .holeTop(forwardHoleTop),
      .biosCsEnable(utilityBusChipSelectA[`FWD_UCS_BIOS_BIT]),
      .forward(decideForward),
      .region(decideRegion)
   );

   //---------------------------------------------------------------------------
   // Memory cycle sequencing
   //---------------------------------------------------------------------------

   cycle_state_t state;
   cycle_state_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (memCycleStart) begin
               next_state = ST_DECIDE;
            end
         end
         ST_DECIDE: begin
            next_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (memCycleEnd) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The cycle address is latched at start so it stays stable while decided.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cycleAddr <= '0;
      end else if (state == ST_IDLE && memCycleStart) begin
         cycleAddr <= memAddr;
      end
   end

   // The verdict is held from ST_DECIDE until the cycle ends; exactly one of the two is high while held.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         decisionValid <= 1'b0;
      end else begin
         decisionValid <= (state == ST_DECIDE);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         forwardToPci <= 1'b0;
      end else if (state == ST_DECIDE) begin
         forwardToPci <= decideForward;
      end else if (state == ST_HOLD && memCycleEnd) begin
         forwardToPci <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         keepOnIsa <= 1'b0;
      end else if (state == ST_DECIDE) begin
         keepOnIsa <= !decideForward;
      end else if (state == ST_HOLD && memCycleEnd) begin
         keepOnIsa <= 1'b0;
      end
   end

   assign cycleBusy = (state != ST_IDLE);

   //---------------------------------------------------------------------------
   // Status and counters
   //---------------------------------------------------------------------------

   region_t lastRegion;
   logic lastForward;
   logic [COUNT_W-1:0] forwardCount;
   logic [COUNT_W-1:0] keepCount;
   logic clearForwardCount;
   logic clearKeepCount;
   logic countForward;
   logic countKeep;

   assign clearForwardCount = writeStrobe && accessSel == SEL_FWD_COUNT;
   assign clearKeepCount = writeStrobe && accessSel == SEL_KEEP_COUNT;
   assign countForward = (state == ST_DECIDE) && decideForward;
   assign countKeep = (state == ST_DECIDE) && !decideForward;

   // Region and verdict of the latest cycle, shown in the status register.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastRegion <= RG_LOW_BASE;
      end else if (state == ST_DECIDE) begin
         lastRegion <= decideRegion;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastForward <= 1'b0;
      end else if (state == ST_DECIDE) begin
         lastForward <= decideForward;
      end
   end

   // A count landing with a clear is kept: the counter restarts at one.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         forwardCount <= '0;
      end else if (clearForwardCount) begin
         forwardCount <= countForward ? COUNT_W'(1) : '0;
      end else if (countForward) begin
         forwardCount <= forwardCount + COUNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         keepCount <= '0;
      end else if (clearKeepCount) begin
         keepCount <= countKeep ? COUNT_W'(1) : '0;
      end else if (countKeep) begin
         keepCount <= keepCount + COUNT_W'(1);
      end
   end

   //---------------------------------------------------------------------------
   // Read data
   //---------------------------------------------------------------------------

   logic [7:0] readByte;

   always_comb begin
      readByte = 8'h00;
      case (accessSel)
         SEL_CONTROL: readByte = forwardRegionControl;
         SEL_ROM: readByte = romBlockForwardEnable;
         SEL_HOLE_BOTTOM: readByte = forwardHoleBottom;
         SEL_HOLE_TOP: readByte = forwardHoleTop;
         SEL_UTILITY_CS: readByte = utilityBusChipSelectA;
         SEL_STATUS: readByte = {1'b0, lastRegion, 1'b0, lastForward, forwardToPci, cycleBusy};
         SEL_FWD_COUNT: readByte = 8'(forwardCount);
         SEL_KEEP_COUNT: readByte = 8'(keepCount);
         default: readByte = 8'h00;
      endcase
   end

   // Read data is captured as the acknowledge rises; unmapped reads give zero.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (busRequest && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000, readByte};
      end
   end

endmodule

// File: tb/fwd_checker.sv
// Port assertions for the ISA-to-PCI memory forward decoder.
`timescale 1ns/1ns
module fwd_checker (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Register bus.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Memory cycle and verdict.
   input wire logic memCycleStart,
   input wire logic memCycleEnd,
   input wire logic decisionValid,
   input wire logic forwardToPci,
   input wire logic keepOnIsa,
   input wire logic cycleBusy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Bus request not answered in one cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Bus acknowledge longer than one cycle");
   read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("Read data above the low byte not zero");
   decide_latency_a: assert property (memCycleStart && !cycleBusy |=> cycleBusy && !decisionValid ##1 decisionValid)
      else $error("Verdict not given two cycles after start");
   verdict_onehot_a: assert property (decisionValid |-> forwardToPci != keepOnIsa)
      else $error("Verdict is not exactly one of forward or keep");
   verdict_pulse_a: assert property (decisionValid |=> !decisionValid)
      else $error("Verdict valid longer than one cycle");
   verdict_hold_a: assert property ((forwardToPci || keepOnIsa) && !memCycleEnd |=>
      $stable(forwardToPci) && $stable(keepOnIsa))
      else $error("Verdict changed during the cycle");
   verdict_release_a: assert property ((forwardToPci || keepOnIsa) && memCycleEnd |=>
      !forwardToPci && !keepOnIsa && !cycleBusy)
      else $error("Verdict not released after cycle end");
   idle_quiet_a: assert property (!cycleBusy |-> !forwardToPci && !keepOnIsa && !decisionValid)
      else $error("Verdict shown while no cycle is running");
endmodule

bind isa_to_pci_memory_forward_decoder fwd_checker u_fwd_checker (.sys_clk(sys_clk), .arst_n(arst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .memCycleStart(memCycleStart), .memCycleEnd(memCycleEnd), .decisionValid(decisionValid),
   .forwardToPci(forwardToPci), .keepOnIsa(keepOnIsa), .cycleBusy(cycleBusy));

// File: tb/isa_cycle_master.sv
// Behavioural ISA master or DMA controller that runs memory cycles.
`timescale 1ns/1ns
module isa_cycle_master (
   // Clock.
   input wire logic sys_clk,
   // Memory cycle.
   output logic memCycleStart,
   output logic memCycleEnd,
   output logic [23:0] memAddr,
   // Verdict.
   input wire logic decisionValid,
   input wire logic forwardToPci,
   input wire logic keepOnIsa
);
   initial begin
      memCycleStart = 1'b0;
      memCycleEnd = 1'b0;
      memAddr = 24'h000000;
   end

   // Address lines are released to the inverse value so a stale address cannot pass for a held one.
   task automatic run(input logic [23:0] a, input int hold, input bit poke, output logic fwd, output logic keep,
      output int lat);
      lat = 0;
      memCycleStart <= 1'b1;
      memAddr <= a;
      @(posedge sys_clk);
      memCycleStart <= 1'b0;
      memAddr <= ~a;
      do begin
         @(posedge sys_clk);
         lat++;
      end while (decisionValid !== 1'b1 && lat < 8);
      fwd = forwardToPci;
      keep = keepOnIsa;
      for (int i = 0; i < hold; i++) begin
         memCycleStart <= poke && i == 0;
         @(posedge sys_clk);
      end
      memCycleStart <= 1'b0;
      memCycleEnd <= 1'b1;
      @(posedge sys_clk);
      memCycleEnd <= 1'b0;
   endtask
endmodule

// File: tb/isa_to_pci_memory_forward_decoder_tb.sv
// Self-checking bench for the ISA-to-PCI memory forward decoder.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checkCount++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module isa_to_pci_memory_forward_decoder_tb;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [11:0] wbAdr = 12'h000;
   logic [31:0] wbDatW = 32'h00000000;
   logic [31:0] wbDatR;
   logic wbAck;
   logic memCycleStart, memCycleEnd, decisionValid, forwardToPci, keepOnIsa, cycleBusy;
   logic [23:0] memAddr;
   int failures = 0;
   int checkCount = 0;
   int seed = 32'h2e5acb72;
   int ctrl = 1;
   int rom = 0;
   int holeBot = 16;
   int holeTop = 15;
   int utilCs = 0;
   int fwdN = 0;
   int keepN = 0;
   int lastSt = 0;
   logic [23:0] lowA [10] = '{24'h000000, 24'h07FFFF, 24'h080000, 24'h09FFFF, 24'h0A0000,
      24'h0BFFFF, 24'h0E0000, 24'h0EFFFF, 24'h0F0000, 24'h0C0000};

   always #50 sys_clk = ~sys_clk;

   isa_to_pci_memory_forward_decoder u_isa_to_pci_memory_forward_decoder (.sys_clk(sys_clk), .arst_n(arst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .memCycleStart(memCycleStart),
      .memCycleEnd(memCycleEnd), .memAddr(memAddr), .decisionValid(decisionValid),
      .forwardToPci(forwardToPci), .keepOnIsa(keepOnIsa), .cycleBusy(cycleBusy));

   isa_cycle_master u_isa_cycle_master (.sys_clk(sys_clk), .memCycleStart(memCycleStart),
      .memCycleEnd(memCycleEnd), .memAddr(memAddr), .decisionValid(decisionValid),
      .forwardToPci(forwardToPci), .keepOnIsa(keepOnIsa));

   function automatic bit expFwd(input logic [23:0] a);
      int k;
      int s;
      k = a[23:10];
      s = a[23:16];
      if (holeTop >= holeBot && s >= holeBot && s <= holeTop) return 1'b0;
      if (k < 512) return ctrl[0];
      if (k < 640) return ctrl[1];
      if (k < 768) return ctrl[2];
      if (k < 896) return rom[(k - 768) / 16];
      if (k < 960) return utilCs[6] ? 1'b0 : ctrl[3];
      if (k < 1024) return 1'b0;
      return a[23:20] <= ctrl[7:4];
   endfunction

   function automatic int regionOf(input logic [23:0] a);
      int k;
      k = a[23:10];
      if (k < 512) return 0;
      if (k < 640) return 1;
      if (k < 768) return 2;
      if (k < 896) return 3;
      if (k < 960) return 4;
      return k < 1024 ? 5 : 6;
   endfunction

   function automatic int holeVal();
      return 16 + (($random(seed) & 32'hFF) % 240);
   endfunction

   task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {2'b00, idx, 2'b00};
      wbDatW <= {24'h000000, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 16);
      if (n >= 16) failures++;
      q = wbDatR[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] idx, input int d);
      logic [7:0] q;
      wbXfer(1'b1, idx, d[7:0], q);
      case (idx)
         8'h48: ctrl = d & 255;
         8'h49: rom = d & 255;
         8'h4A: holeBot = d & 255;
         8'h4B: holeTop = d & 255;
         8'h50: utilCs = d & 255;
         8'h52: fwdN = 0;
         8'h53: keepN = 0;
         default: ;
      endcase
   endtask

   task automatic rdChk(input logic [7:0] idx, input int exp);
      logic [7:0] q;
      wbXfer(1'b0, idx, 8'h00, q);
      `CHK($sformatf("register %0h", idx), exp, q)
   endtask

   task automatic regsChk();
      rdChk(8'h48, ctrl);
      rdChk(8'h49, rom);
      rdChk(8'h4A, holeBot);
      rdChk(8'h4B, holeTop);
      rdChk(8'h50, utilCs);
      rdChk(8'h51, lastSt);
      rdChk(8'h52, fwdN & 255);
      rdChk(8'h53, keepN & 255);
      rdChk(8'h7F, 0);
   endtask

   task automatic memChk(input logic [23:0] a, input int hold, input bit poke);
      logic f;
      logic k;
      int lat;
      bit e;
      e = expFwd(a);
      if (e) fwdN++;
      else keepN++;
      lastSt = (regionOf(a) << 4) | (e ? 4 : 0);
      u_isa_cycle_master.run(a, hold, poke, f, k, lat);
      `CHK("latency", 2, lat)
      `CHK($sformatf("forward %h", a), e, f)
      `CHK($sformatf("keep %h", a), !e, k)
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #2000000;
      failures++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      wr(8'h7F, 8'hFF);
      regsChk();
      memChk(24'h100000, 0, 1'b0);
      $display("Test reset values done");
      for (int i = 0; i < 32; i++) begin
         wr(8'h48, i & 15);
         wr(8'h50, (i & 16) << 2);
         foreach (lowA[j]) memChk(lowA[j], i % 3, i == 5);
      end
      $display("Test low blocks done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h49, i == 0 ? 255 : $random(seed));
         for (int b = 0; b < 8; b++) memChk(24'(24'h0C0000 + b * 16384 + (i[0] ? 16383 : 0)), 0, 1'b0);
      end
      $display("Test rom blocks done");
      for (int n = 0; n < 16; n++) begin
         wr(8'h48, n << 4);
         memChk(24'((n << 20) + 24'h0FFFFF), 0, 1'b0);
         memChk(24'((n + 1) << 20), 1, 1'b0);
      end
      $display("Test region top done");
      wr(8'h48, 8'hF0);
      for (int i = 0; i < 12; i++) begin
         wr(8'h4A, holeVal());
         wr(8'h4B, i < 2 ? holeBot - i : holeVal());
         regsChk();
         for (int j = 0; j < 4; j++)
            memChk(24'(j < 2 ? (holeBot << 16) - j : ((holeTop + j - 2) << 16) + 65535 * (3 - j)), j, 1'b0);
      end
      $display("Test hole done");
      wr(8'h52, 0);
      wr(8'h53, 0);
      for (int i = 0; i < 40; i++) begin
         wr(8'h48, $random(seed));
         wr(8'h49, $random(seed));
         wr(8'h50, (i & 1) << 6);
         wr(8'h4A, holeVal());
         wr(8'h4B, holeVal());
         memChk(24'($random(seed)), i % 4, i[1]);
      end
      regsChk();
      $display("Test random cycles done");
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      ctrl = 1;
      rom = 0;
      holeBot = 16;
      holeTop = 15;
      utilCs = 0;
      fwdN = 0;
      keepN = 0;
      lastSt = 0;
      @(posedge sys_clk);
      regsChk();
      $display("Test second reset done");
      conclude();
   end
endmodule
